// ===== core/sqd_pkg.sv
/*
 * Shared constants of the squib diagnostic status and fire-enable block: filter
 * and tick timing, counter widths, reset values and status byte bit positions.
 * Assumes a single 50 MHz clock.
 */
package sqd_pkg;

	// ===========================================================
	// Clock and timing
	localparam int CLK_HZ          = 50_000_000;
	localparam int FILT_TIME_US    = 12_000;
	localparam int TICK_TIME_US    = 1_000;
	localparam int FILT_CYCLES     = (CLK_HZ / 1_000_000) * FILT_TIME_US;
	localparam int TICK_CYCLES     = (CLK_HZ / 1_000_000) * TICK_TIME_US;
	localparam int HOLD_W          = 8;
	localparam logic [7:0] HOLD_RST = 8'h00;

	// ===========================================================
	// Status byte bit positions
	localparam int ST_FEN1_BIT     = 0;
	localparam int ST_FEN2_BIT     = 1;
	localparam int ST_ACT1_BIT     = 2;
	localparam int ST_ACT2_BIT     = 3;
	localparam logic [7:0] RES_RST = 8'hff;

endpackage

// ===== core/sqd_fen_chan.sv
/*
 * One fire-enable channel: synchroniser, glitch filter and latch-and-hold timer.
 * Assumes the pin is asynchronous and a shared 1 ms tick pulse.
 */
module sqd_fen_chan #(
	parameter int FILT_CYC = 600_000
) (
	// Clock and reset
	input  wire logic       i_clk,
	input  wire logic       i_rst_n,
	// Pin, tick and programming
	input  wire logic       i_pin,
	input  wire logic       i_tick,
	input  wire logic [7:0] i_hold_ms,
	// Results
	output logic            o_pin_sync,
	output logic            o_active
);
	// The filter counter is 24 bits wide, so longer intervals cannot be served
	if (FILT_CYC < 1 || FILT_CYC > 16_777_215) begin : g_bad_filt
		$error("FILT_CYC must lie between 1 and 16777215");
	end

	typedef struct packed {
		logic        s1;
		logic        s2;
		logic [23:0] fcnt;
		logic        qual;
		logic [7:0]  hold;
		logic        act;
	} sqd_chan_t;

	sqd_chan_t st_q, st_d;

	always_comb begin
		st_d = st_q;
		st_d.s1 = i_pin;
		st_d.s2 = st_q.s1;
		// Filter: must stay high for the whole interval, any low restarts it
		if (!st_q.s2) begin
			st_d.fcnt = '0;
			st_d.qual = 1'b0;
		end else if (st_q.fcnt < 24'(FILT_CYC)) begin
			st_d.fcnt = st_q.fcnt + 24'h000001;
		end else begin
			st_d.qual = 1'b1;
		end
		// Reload on rising qualified enable, count down on ticks while low
		if (st_d.qual && !st_q.qual) begin
			st_d.hold = i_hold_ms;
		end else if (!st_q.qual && i_tick && st_q.hold != 8'h00) begin
			st_d.hold = st_q.hold - 8'h01;
		end
		st_d.act = st_d.qual || (st_d.hold != 8'h00);
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign o_pin_sync = st_q.s2;
	assign o_active   = st_q.act;

	// ===========================================================
	// Assertions
	AST_GLITCH: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		$rose(st_q.qual) |-> $past(st_q.s2) && st_q.fcnt == 24'(FILT_CYC))
		else $error("enable qualified without full filter interval");
	AST_RELOAD: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		$rose(st_q.qual) |-> st_q.hold == $past(i_hold_ms))
		else $error("hold not reloaded on qualified rise");
	AST_HOLD: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(!st_q.qual && st_q.hold != 8'h00) |-> st_q.act)
		else $error("enable dropped while hold running");
endmodule

// ===== core/sqd_top.sv
/*
 * Digital status and control of a four-channel squib driver: harness short
 * flags, low-side continuity, resistance comparator byte, line-to-line short
 * flags, fire-enable qualification with latch-and-hold, and hold programming.
 * Assumes the SPI front end decodes commands and pulses i_cmd_done per valid
 * command, and that analogue comparator outputs are already synchronous.
 */
module sqd_top #(
	parameter int FILT_CYC = sqd_pkg::FILT_CYCLES,
	parameter int TICK_CYC = sqd_pkg::TICK_CYCLES
) (
	// Clock and reset
	input  wire logic       i_clk,
	input  wire logic       i_rst_n,
	// Fire-enable pins
	input  wire logic       i_fire_enable_one,
	input  wire logic       i_fire_enable_two,
	// Command strobes from the serial front end
	input  wire logic       i_cmd_done,
	input  wire logic       i_prog_one,
	input  wire logic       i_prog_two,
	input  wire logic [7:0] i_prog_ms,
	input  wire logic [3:0] i_fire_cmd,
	// Analogue comparator results
	input  wire logic       i_std_test,
	input  wire logic       i_cmp_batt,
	input  wire logic       i_cmp_gnd,
	input  wire logic       i_open_test,
	input  wire logic       i_cont_test,
	input  wire logic       i_cont_ok,
	input  wire logic       i_res_test,
	input  wire logic [7:0] i_res_cmp,
	input  wire logic       i_l2l_test,
	input  wire logic       i_l2l_line_ok,
	input  wire logic [2:0] i_l2l_pair,
	// Status outputs
	output logic            o_no_battery_short_flag,
	output logic            o_no_ground_short_flag,
	output logic            o_open_squib_battery_ok_flag,
	output logic            o_open_squib_ground_ok_flag,
	output logic            o_low_side_continuity_flag,
	output logic [7:0]      o_res_result,
	output logic            o_line_test_current_flag,
	output logic [2:0]      o_line_pair_short_flag,
	output logic [7:0]      o_fen_status,
	output logic [7:0]      o_hold_one_ms,
	output logic [7:0]      o_hold_two_ms,
	output logic [3:0]      o_drive_on,
	output logic            o_firing
);
	// The prescaler is 23 bits wide and must reach TICK_CYC - 1
	if (TICK_CYC < 1 || TICK_CYC > 8_388_608) begin : g_bad_tick
		$error("TICK_CYC must lie between 1 and 8388608");
	end

	typedef struct packed {
		logic        nb;
		logic        ng;
		logic        onb;
		logic        ong;
		logic        cont;
		logic [7:0]  res;
		logic        lt;
		logic [2:0]  lp;
		logic [7:0]  fst;
		logic [7:0]  h1;
		logic [7:0]  h2;
		logic [3:0]  drv;
		logic        fir;
		logic [22:0] pre;
		logic        tick;
	} sqd_state_t;

	sqd_state_t st_q, st_d;
	logic       en1_sync;
	logic       en2_sync;
	logic       en1_act;
	logic       en2_act;

	// ===========================================================
	// Fire-enable channels
	sqd_fen_chan #(.FILT_CYC(FILT_CYC)) u_fen_one (
		.i_clk      (i_clk),
		.i_rst_n    (i_rst_n),
		.i_pin      (i_fire_enable_one),
		.i_tick     (st_q.tick),
		.i_hold_ms  (st_q.h1),
		.o_pin_sync (en1_sync),
		.o_active   (en1_act)
	);

	sqd_fen_chan #(.FILT_CYC(FILT_CYC)) u_fen_two (
		.i_clk      (i_clk),
		.i_rst_n    (i_rst_n),
		.i_pin      (i_fire_enable_two),
		.i_tick     (st_q.tick),
		.i_hold_ms  (st_q.h2),
		.o_pin_sync (en2_sync),
		.o_active   (en2_act)
	);

	// ===========================================================
	// Next state
	always_comb begin
		st_d = st_q;
		// 1 ms prescaler shared by both hold timers
		if (st_q.pre >= 23'(TICK_CYC - 1)) begin
			st_d.pre  = '0;
			st_d.tick = 1'b1;
		end else begin
			st_d.pre  = st_q.pre + 23'h000001;
			st_d.tick = 1'b0;
		end
		if (i_std_test) begin
			st_d.nb = !i_cmp_batt;
			st_d.ng = !i_cmp_gnd;
		end
		if (i_open_test) begin
			st_d.onb = !i_cmp_batt;
			st_d.ong = !i_cmp_gnd;
		end
		// Continuity clears once reported; a new test in the same cycle wins
		if (i_cont_test) begin
			st_d.cont = i_cont_ok;
		end else if (i_cmd_done) begin
			st_d.cont = 1'b0;
		end
		if (i_res_test && !st_q.fir) begin
			st_d.res = i_res_cmp;
		end
		if (i_l2l_test) begin
			// Two or more pairs hit means three lines joined, whatever the line under test reports; both results zeroed
			if ((i_l2l_pair[0] + i_l2l_pair[1] + i_l2l_pair[2]) > 2'd1) begin
				st_d.lt = 1'b0;
				st_d.lp = 3'h0;
			end else begin
				st_d.lt = i_l2l_line_ok;
				st_d.lp = i_l2l_pair;
			end
		end
		// Unlock byte is assumed consumed upstream; only the delay byte lands here
		if (i_prog_one && !st_q.fir) begin
			st_d.h1 = i_prog_ms;
		end
		if (i_prog_two && !st_q.fir) begin
			st_d.h2 = i_prog_ms;
		end
		st_d.fst = 8'h00;
		st_d.fst[sqd_pkg::ST_FEN1_BIT] = en1_sync;
		st_d.fst[sqd_pkg::ST_FEN2_BIT] = en2_sync;
		st_d.fst[sqd_pkg::ST_ACT1_BIT] = en1_act;
		st_d.fst[sqd_pkg::ST_ACT2_BIT] = en2_act;
		// Channels 0,1 gated by enable one, 2,3 by enable two
		st_d.drv = i_fire_cmd & {en2_act, en2_act, en1_act, en1_act};
		st_d.fir = |st_d.drv;
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st_q     <= '0;
			st_q.nb  <= 1'b1;
			st_q.ng  <= 1'b1;
			st_q.onb <= 1'b1;
			st_q.ong <= 1'b1;
			st_q.res <= sqd_pkg::RES_RST;
			st_q.h1  <= sqd_pkg::HOLD_RST;
			st_q.h2  <= sqd_pkg::HOLD_RST;
		end else begin
			st_q <= st_d;
		end
	end

	assign o_no_battery_short_flag      = st_q.nb;
	assign o_no_ground_short_flag       = st_q.ng;
	assign o_open_squib_battery_ok_flag = st_q.onb;
	assign o_open_squib_ground_ok_flag  = st_q.ong;
	assign o_low_side_continuity_flag   = st_q.cont;
	assign o_res_result                 = st_q.res;
	assign o_line_test_current_flag     = st_q.lt;
	assign o_line_pair_short_flag       = st_q.lp;
	assign o_fen_status                 = st_q.fst;
	assign o_hold_one_ms                = st_q.h1;
	assign o_hold_two_ms                = st_q.h2;
	assign o_drive_on                   = st_q.drv;
	assign o_firing                     = st_q.fir;

	// ===========================================================
	// Assertions
	sequence s_res_attempt;
		i_res_test && st_q.fir;
	endsequence

	AST_NO_BATT: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		i_std_test |=> o_no_battery_short_flag == !$past(i_cmp_batt))
		else $error("battery short flag wrong");
	AST_OPEN_GND: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		i_open_test |=> o_open_squib_ground_ok_flag == !$past(i_cmp_gnd))
		else $error("open-squib ground flag wrong");
	AST_CONT_SET: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		i_cont_test |=> o_low_side_continuity_flag == $past(i_cont_ok))
		else $error("continuity flag wrong");
	AST_CONT_CLR: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(i_cmd_done && !i_cont_test) |=> !o_low_side_continuity_flag)
		else $error("continuity not cleared after command");
	AST_RES_BLOCK: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		s_res_attempt |=> $stable(o_res_result))
		else $error("resistance updated during firing");
	AST_L2L_MULTI: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(i_l2l_test && $countones(i_l2l_pair) > 1) |=> (o_line_pair_short_flag == 3'h0 && !o_line_test_current_flag))
		else $error("multi-line short not zeroed");
	AST_BLOCK_FIRE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		!en1_act |=> o_drive_on[1:0] == 2'b00)
		else $error("drive on without enable");
	AST_FEN_STAT: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		##1 o_fen_status[sqd_pkg::ST_FEN1_BIT] == $past(en1_sync))
		else $error("enable status not reflecting pin");

	// ===========================================================
	// Capture assertions, built from the strobe sequences
	// Each capture lands one edge after its strobe and is judged against the sampled inputs
	sequence s_std_capture;
		i_std_test;
	endsequence

	sequence s_open_capture;
		i_open_test;
	endsequence

	sequence s_res_capture;
		i_res_test && !st_q.fir;
	endsequence

	sequence s_l2l_single;
		i_l2l_test && $countones(i_l2l_pair) <= 1;
	endsequence

	AST_NO_GND: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		s_std_capture |=> o_no_ground_short_flag == !$past(i_cmp_gnd))
		else $error("ground short flag wrong");
	AST_OPEN_BATT: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		s_open_capture |=> o_open_squib_battery_ok_flag == !$past(i_cmp_batt))
		else $error("open-squib battery flag wrong");
	AST_RES_CAPTURE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		s_res_capture |=> o_res_result == $past(i_res_cmp))
		else $error("resistance byte not captured");
	AST_L2L_LINE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		s_l2l_single |=> o_line_test_current_flag == $past(i_l2l_line_ok))
		else $error("line under test flag wrong");
	AST_L2L_PAIR: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		s_l2l_single |=> o_line_pair_short_flag == $past(i_l2l_pair))
		else $error("pair short flags wrong");

	// ===========================================================
	// Firing and hold programming assertions
	// A refused delay byte must leave the stored value alone
	sequence s_prog_one_taken;
		i_prog_one && !st_q.fir;
	endsequence

	sequence s_prog_two_taken;
		i_prog_two && !st_q.fir;
	endsequence

	AST_PROG_ONE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		s_prog_one_taken |=> o_hold_one_ms == $past(i_prog_ms))
		else $error("hold one not programmed");
	AST_PROG_TWO: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		s_prog_two_taken |=> o_hold_two_ms == $past(i_prog_ms))
		else $error("hold two not programmed");
	AST_PROG_BLOCK: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(i_prog_one && st_q.fir) |=> $stable(o_hold_one_ms))
		else $error("hold programmed during firing");
	AST_BLOCK_FIRE_TWO: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		!en2_act |=> o_drive_on[3:2] == 2'b00)
		else $error("drive on without enable two");
	AST_DRIVE_FOLLOW: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(en1_act && i_fire_cmd[0]) |=> o_drive_on[0])
		else $error("driver not following enable");
	AST_FEN_STAT_TWO: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		##1 o_fen_status[sqd_pkg::ST_FEN2_BIT] == $past(en2_sync))
		else $error("enable two status not reflecting pin");
	AST_TICK_PULSE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(st_q.tick && TICK_CYC > 1) |=> !st_q.tick)
		else $error("tick longer than one cycle");
endmodule

// ===== verif/sqd_host.sv
/*
 * Host model: issues the decoded serial command strobes and the hold delay byte.
 * Assumes one bench process calls its tasks and owns the comparator inputs.
 */
module sqd_host (
	input  wire logic       i_clk,
	output logic [7:0]      o_stb,
	output logic [7:0]      o_prog_ms
);
	timeunit 1ns;
	timeprecision 1ns;

	// ===========================================================
	// Strobes: 0 done, 1/2 delay byte, 3 std, 4 open, 5 cont, 6 res, 7 l2l
	initial begin
		o_stb = 8'h00;
		o_prog_ms = 8'h00;
	end

	// Extra idle cycles before a strobe let the line RC settle first
	task automatic pulse(input int idx, input int settle);
		repeat (settle) @(posedge i_clk);
		@(posedge i_clk);
		#1;
		o_stb[idx] = 1'b1;
		@(posedge i_clk);
		#1;
		o_stb[idx] = 1'b0;
	endtask

	// Unlock byte is taken upstream, so only the delay byte arrives here
	task automatic prog(input int ch, input logic [7:0] ms);
		o_prog_ms = ms;
		pulse(ch, 0);
	endtask
endmodule

// ===== verif/tb_sqd_top.sv
/*
 * Self-checking bench of the squib status and fire-enable block.
 * Assumes shortened filter and tick counts; the host model drives the strobes.
 */
module tb_sqd_top;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int FC = 20;
	localparam int TC = 5;
	logic       clk, rst_n, fen1, fen2, batt, gnd, cok, lok;
	logic       nb, ng, ob, og, cont, line, firing;
	logic [7:0] stb, pms, rcmp, res, fst, h1, h2, r;
	logic [3:0] fire, drv;
	logic [2:0] pair, lpr;
	int         seed, mismatches, checks_done, cyc;
	int         m_res, m_lp, m_lt;
	int         vec_q[$];

	sqd_host u_host (.i_clk(clk), .o_stb(stb), .o_prog_ms(pms));
	sqd_top #(.FILT_CYC(FC), .TICK_CYC(TC)) u_sqd_top (
		.i_clk(clk), .i_rst_n(rst_n), .i_fire_enable_one(fen1), .i_fire_enable_two(fen2),
		.i_cmd_done(stb[0]), .i_prog_one(stb[1]), .i_prog_two(stb[2]), .i_prog_ms(pms),
		.i_fire_cmd(fire), .i_std_test(stb[3]), .i_cmp_batt(batt), .i_cmp_gnd(gnd),
		.i_open_test(stb[4]), .i_cont_test(stb[5]), .i_cont_ok(cok), .i_res_test(stb[6]),
		.i_res_cmp(rcmp), .i_l2l_test(stb[7]), .i_l2l_line_ok(lok), .i_l2l_pair(pair),
		.o_no_battery_short_flag(nb), .o_no_ground_short_flag(ng),
		.o_open_squib_battery_ok_flag(ob), .o_open_squib_ground_ok_flag(og),
		.o_low_side_continuity_flag(cont), .o_res_result(res), .o_line_test_current_flag(line),
		.o_line_pair_short_flag(lpr), .o_fen_status(fst), .o_hold_one_ms(h1),
		.o_hold_two_ms(h2), .o_drive_on(drv), .o_firing(firing));

	// ===========================================================
	// Clock, timeout and reporting
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic close_out();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			mismatches++;
			close_out();
		end
	end

	task automatic wt(input int c);
		repeat (c) @(posedge clk);
		#1;
	endtask

	// Line-to-line model: more than one pair hit means three lines joined, all zero
	task automatic model_l2l(input int v);
		if ($countones(v[2:0]) > 1) begin
			m_lp = 0;
			m_lt = 0;
		end else begin
			m_lp = v[2:0];
			m_lt = v[7];
		end
	endtask

	// ===========================================================
	// Scenarios
	initial begin
		seed = 11;
		{rst_n, fen1, fen2, batt, gnd, cok, lok} = 7'h00;
		{rcmp, pair, fire} = 15'h0000;
		repeat (12) @(posedge clk);
		#1;
		rst_n = 1'b1;
		wt(1);
		chk("rst flags", {4'h0, nb, ng, ob, og}, 8'h0f);
		chk("rst res", res, 8'hff);
		chk("rst hold", h1 | h2, 8'h00);
		$display("test reset done");
		for (int i = 0; i < 8; i++) begin
			{batt, gnd} = 2'($random(seed));
			u_host.pulse(4, 0);
			chk("open", {6'h0, ob, og}, {6'h0, ~batt, ~gnd});
			u_host.pulse(3, 2);
			chk("std", {6'h0, nb, ng}, {6'h0, ~batt, ~gnd});
		end
		cok = 1'b1;
		u_host.pulse(5, 0);
		chk("cont", {7'h0, cont}, 8'h01);
		u_host.pulse(0, 0);
		chk("cont clr", {7'h0, cont}, 8'h00);
		u_host.pulse(5, 0);
		chk("cont again", {7'h0, cont}, 8'h01);
		cok = 1'b0;
		u_host.pulse(5, 0);
		chk("cont open", {7'h0, cont}, 8'h00);
		repeat (12) vec_q.push_back(int'(8'($random(seed))));
		while (vec_q.size() > 0) begin
			r = 8'(vec_q.pop_front());
			rcmp = r;
			lok = r[7];
			pair = r[2:0];
			u_host.pulse(6, 0);
			m_res = r;
			chk("res", res, 8'(m_res));
			u_host.pulse(7, 0);
			model_l2l(r);
			chk("pair", {5'h0, lpr}, 8'(m_lp));
			chk("line", {7'h0, line}, 8'(m_lt));
		end
		$display("test diagnostics done");
		u_host.prog(1, 8'hff);
		u_host.prog(2, 8'h01);
		chk("hold1", h1, 8'hff);
		chk("hold2", h2, 8'h01);
		u_host.prog(1, 8'h03);
		u_host.prog(2, 8'h00);
		fire = 4'hf;
		fen1 = 1'b1;
		wt(FC / 2);
		fen1 = 1'b0;
		for (int i = 0; i < FC + 6; i++) begin
			wt(1);
			chk("glitch", drv | fst[2], 8'h00);
		end
		fen1 = 1'b1;
		wt(4);
		chk("pin1", {7'h0, fst[0]}, 8'h01);
		wt(FC - 8);
		chk("filt early", {7'h0, fst[2]}, 8'h00);
		wt(12);
		chk("filt on", {7'h0, fst[2]}, 8'h01);
		chk("drive", {4'h0, drv}, 8'h03);
		chk("firing", {7'h0, firing}, 8'h01);
		rcmp = ~r;
		u_host.pulse(6, 0);
		chk("res firing", res, 8'(m_res));
		u_host.prog(1, 8'h07);
		chk("prog firing", h1, 8'h03);
		fen1 = 1'b0;
		wt(10);
		chk("held", {3'h0, fst[2], drv}, 8'h13);
		wt(25);
		chk("expired", {3'h0, fst[2], drv}, 8'h00);
		chk("fired off", {7'h0, firing}, 8'h00);
		fen1 = 1'b1;
		wt(FC + 6);
		chk("re-enable", {4'h0, drv}, 8'h03);
		fen2 = 1'b1;
		wt(FC + 6);
		chk("drive2", {4'h0, drv}, 8'h0f);
		chk("status2", {4'h0, fst[3:0]}, 8'h0f);
		fen2 = 1'b0;
		wt(8);
		chk("no hold", {4'h0, drv}, 8'h03);
		chk("status1", {4'h0, fst[3:0]}, 8'h05);
		fen1 = 1'b0;
		wt(10);
		chk("reload", {4'h0, drv}, 8'h03);
		$display("test fire enable done");
		rst_n = 1'b0;
		fire = 4'h0;
		fen1 = 1'b1;
		wt(1);
		chk("mid rst", h1 | h2 | {3'h0, firing, drv}, 8'h00);
		rst_n = 1'b1;
		wt(2);
		chk("rel flags", {4'h0, nb, ng, ob, og}, 8'h0f);
		chk("rel status", fst, 8'h00);
		wt(1);
		chk("rel pin", fst, 8'h01);
		fire = 4'h3;
		wt(FC + 3);
		chk("rel drive", {4'h0, drv}, 8'h03);
		fen1 = 1'b0;
		wt(6);
		chk("default hold", {4'h0, drv}, 8'h00);
		$display("test mid reset done");
		close_out();
	end
endmodule
